/* hw/gpwk_top.sv */
// Summary of operation
// RQ1: a read of an input pin returns the live pin level taken at the read edge.
// RQ2: a port data latch holds its value until software writes it again.
// RQ3: the pull-high is applied only to an input pin whose pull-high bit is set.
// RQ4: port A pull-high enable has eight read/write bits, 1 enables, reset 0.
// RQ5: port B pull-high enable has bits 5 to 0 only, 1 enables, reset 0.
// RQ6: unimplemented register bits ignore writes and read as zero.
// RQ7: in sleep or idle a falling edge on a wake-enabled port A pin requests wake-up.
// RQ8: port A wake enable has eight read/write bits, 1 enables, reset 0.
// RQ9: direction bit 1 is an input, 0 a CMOS output driven from the latch.
// RQ10: port B direction has bits 5 to 0, same coding, effective at once.
// RQ11: reading an output pin returns the latch, not the pin level.
// RQ12: port A pin-share bits 6, 4, 2, 0 pick the timer output or its inverse.
// RQ13: an analog function wins over a digital one, and all analog users see the pin.
// RQ14: reset sets every data and direction register to all ones.
// RQ15: the remap register routes timer clock, capture input and interrupt pins.
// RQ16: a pin given to a timer output is driven by it regardless of the latch.
// RQ17: wake detection synchronises the pin and fires once per falling edge.
`timescale 1ns/1ps
module gpwk_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire gpwk_pkg::gpwk_bus_req_t bus_req,
   output logic [7:0] rd_data,
   input wire logic [gpwk_pkg::PA_W-1:0] pa_in,
   output logic [gpwk_pkg::PA_W-1:0] pa_out,
   output logic [gpwk_pkg::PA_W-1:0] pa_oe_n,
   output logic [gpwk_pkg::PA_W-1:0] pa_pull,
   input wire logic [gpwk_pkg::PA_W-1:0] pa_analog_en,
   input wire logic [gpwk_pkg::PB_W-1:0] pb_in,
   output logic [gpwk_pkg::PB_W-1:0] pb_out,
   output logic [gpwk_pkg::PB_W-1:0] pb_oe_n,
   output logic [gpwk_pkg::PB_W-1:0] pb_pull,
   input wire logic [gpwk_pkg::PB_W-1:0] pb_analog_en,
   input wire logic [gpwk_pkg::PB_W-1:0] pb_alt_out,
   input wire logic timer_output,
   input wire logic timer_output_inverted,
   output logic timer_clock_input,
   output logic timer_capture_input,
   output logic ext_irq_input,
   input wire logic sleep_mode,
   output logic wake_req
);
   gpwk_pkg::gpwk_regs_t r_q;
   gpwk_pkg::gpwk_regs_t r_d;
   logic [gpwk_pkg::PA_W-1:0] pa_share_en;
   logic [gpwk_pkg::PA_W-1:0] pa_share_val;
   logic [gpwk_pkg::PB_W-1:0] pb_share_en;
   logic [7:0] pa_view;
   logic [7:0] pb_view;
   logic wr_hit;

   // port view: live pin on inputs, latch on outputs
   always_comb begin
      pa_view = (r_q.pa_dir & pa_in) | (~r_q.pa_dir & r_q.pa_data); // RQ1 RQ11
      pb_view = ((r_q.pb_dir & {2'h0, pb_in}) | (~r_q.pb_dir & r_q.pb_data))
         & gpwk_pkg::MASK_PB; // RQ6
   end

   // register writes, masked to the implemented bits, and the read sample
   always_comb begin
      r_d = r_q;
      wr_hit = bus_req.wr;
      if (bus_req.wr) begin
         case (bus_req.addr)
            gpwk_pkg::OFS_PA_DATA: r_d.pa_data = bus_req.wdata; // RQ2
            gpwk_pkg::OFS_PA_DIR: r_d.pa_dir = bus_req.wdata; // RQ9
            gpwk_pkg::OFS_PA_PU: r_d.pa_pu = bus_req.wdata; // RQ4
            gpwk_pkg::OFS_PA_WU: r_d.pa_wu = bus_req.wdata; // RQ8
            gpwk_pkg::OFS_PB_DATA: r_d.pb_data = bus_req.wdata & gpwk_pkg::MASK_PB; // RQ2 RQ6
            gpwk_pkg::OFS_PB_DIR: r_d.pb_dir = bus_req.wdata & gpwk_pkg::MASK_PB; // RQ10
            gpwk_pkg::OFS_PB_PU: r_d.pb_pu = bus_req.wdata & gpwk_pkg::MASK_PB; // RQ5
            gpwk_pkg::OFS_PA_SR: r_d.pa_sr = bus_req.wdata & gpwk_pkg::MASK_PA_SR; // RQ12
            gpwk_pkg::OFS_PB_SR: r_d.pb_sr = bus_req.wdata & gpwk_pkg::MASK_PB_SR; // RQ6
            gpwk_pkg::OFS_IFS: r_d.ifs = bus_req.wdata & gpwk_pkg::MASK_IFS; // RQ15
            default: wr_hit = 1'b0;
         endcase
      end
      // no earlier capture: the pin is taken at the read edge itself
      if (bus_req.rd) begin
         case (bus_req.addr)
            gpwk_pkg::OFS_PA_DATA: r_d.rd_data = pa_view; // RQ1
            gpwk_pkg::OFS_PA_DIR: r_d.rd_data = r_q.pa_dir;
            gpwk_pkg::OFS_PA_PU: r_d.rd_data = r_q.pa_pu;
            gpwk_pkg::OFS_PA_WU: r_d.rd_data = r_q.pa_wu;
            gpwk_pkg::OFS_PB_DATA: r_d.rd_data = pb_view;
            gpwk_pkg::OFS_PB_DIR: r_d.rd_data = r_q.pb_dir;
            gpwk_pkg::OFS_PB_PU: r_d.rd_data = r_q.pb_pu;
            gpwk_pkg::OFS_PA_SR: r_d.rd_data = r_q.pa_sr;
            gpwk_pkg::OFS_PB_SR: r_d.rd_data = r_q.pb_sr;
            gpwk_pkg::OFS_IFS: r_d.rd_data = r_q.ifs;
            default: r_d.rd_data = 8'h00;
         endcase
      end
   end

   // all implemented data and direction bits come up as ones: inputs, driving high later
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_q.pa_data <= gpwk_pkg::RST_PA_DATA; // RQ14
         r_q.pa_dir <= gpwk_pkg::RST_PA_DIR; // RQ14
         r_q.pa_pu <= gpwk_pkg::RST_CLEAR; // RQ4
         r_q.pa_wu <= gpwk_pkg::RST_CLEAR; // RQ8
         r_q.pb_data <= gpwk_pkg::RST_PB_DATA; // RQ14
         r_q.pb_dir <= gpwk_pkg::RST_PB_DIR; // RQ14
         r_q.pb_pu <= gpwk_pkg::RST_CLEAR; // RQ5
         r_q.pa_sr <= gpwk_pkg::RST_CLEAR; // RQ12
         r_q.pb_sr <= gpwk_pkg::RST_CLEAR;
         r_q.ifs <= gpwk_pkg::RST_CLEAR;
         r_q.rd_data <= 8'h00;
      end else begin
         r_q <= r_d;
      end
   end

   assign rd_data = r_q.rd_data;

   // pin-share: bit 6 drives pin 5 and bit 2 pin 1 inverted, bits 4 and 0 pins 2 and 0
   always_comb begin
      pa_share_en = '0;
      pa_share_val = '0;
      pa_share_en[5] = r_q.pa_sr[gpwk_pkg::SR_PIN6]; // RQ12
      pa_share_val[5] = timer_output_inverted;
      pa_share_en[2] = r_q.pa_sr[gpwk_pkg::SR_PIN4]; // RQ12
      pa_share_val[2] = timer_output;
      pa_share_en[1] = r_q.pa_sr[gpwk_pkg::SR_PIN2]; // RQ12
      pa_share_val[1] = timer_output_inverted;
      pa_share_en[0] = r_q.pa_sr[gpwk_pkg::SR_PIN0]; // RQ12
      pa_share_val[0] = timer_output;
      pb_share_en = r_q.pb_sr[gpwk_pkg::PB_W-1:0];
   end

   // one pad slice per port
   gpwk_pad #(.W(gpwk_pkg::PA_W)) u_pad_a (
      .data(r_q.pa_data),
      .dir(r_q.pa_dir),
      .pu(r_q.pa_pu),
      .share_en(pa_share_en),
      .share_val(pa_share_val),
      .analog_en(pa_analog_en),
      .pin_out(pa_out),
      .pin_oe_n(pa_oe_n),
      .pin_pull(pa_pull)
   );

   gpwk_pad #(.W(gpwk_pkg::PB_W)) u_pad_b (
      .data(r_q.pb_data[gpwk_pkg::PB_W-1:0]),
      .dir(r_q.pb_dir[gpwk_pkg::PB_W-1:0]),
      .pu(r_q.pb_pu[gpwk_pkg::PB_W-1:0]),
      .share_en(pb_share_en),
      .share_val(pb_alt_out),
      .analog_en(pb_analog_en),
      .pin_out(pb_out),
      .pin_oe_n(pb_oe_n),
      .pin_pull(pb_pull)
   );

   // input remap; timers and interrupt logic do their own synchronising
   always_comb begin
      timer_clock_input = r_q.ifs[gpwk_pkg::IFS_TCK_BIT] ? pa_in[6] : pa_in[7]; // RQ15
      timer_capture_input = r_q.ifs[gpwk_pkg::IFS_CAP_BIT] ? pa_in[0] : pa_in[6]; // RQ15
      case (r_q.ifs[gpwk_pkg::IFS_IRQ_LSB +: 2])
         gpwk_pkg::IRQ_ON_PIN5: ext_irq_input = pa_in[5]; // RQ15
         gpwk_pkg::IRQ_ON_PIN2: ext_irq_input = pa_in[2];
         gpwk_pkg::IRQ_ON_PIN3: ext_irq_input = pa_in[3];
         gpwk_pkg::IRQ_ON_PIN7: ext_irq_input = pa_in[7];
         default: ext_irq_input = pa_in[5];
      endcase
   end

   // falling-edge wake detector on port A
   gpwk_wake u_wake (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_in(pa_in),
      .wake_en(r_q.pa_wu),
      .sleep_mode(sleep_mode),
      .wake_req(wake_req)
   );

   AST_RD_LIVE: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
      (bus_req.rd && bus_req.addr == gpwk_pkg::OFS_PA_DATA)
      |=> rd_data == (($past(r_q.pa_dir) & $past(pa_in))
                      | (~$past(r_q.pa_dir) & $past(r_q.pa_data))))
      else $error("port A read did not return pin on inputs and latch on outputs");
   AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      !(bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PA_DATA) |=> $stable(r_q.pa_data))
      else $error("port A latch changed without a write");
   AST_NO_PULL_OUT: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
      ((pa_pull & ~r_q.pa_dir) == '0) && ((pa_pull & ~r_q.pa_pu) == '0))
      else $error("pull-high on an output pin or a disabled pin");
   AST_PU_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PA_PU) |=> r_q.pa_pu == $past(bus_req.wdata))
      else $error("pull-high enable write not stored");
   AST_PB_RSVD: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
      (bus_req.rd && bus_req.addr == gpwk_pkg::OFS_PB_PU) |=> rd_data[7:6] == 2'h0)
      else $error("port B pull-high upper bits read nonzero");
   AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      ((r_q.ifs & ~gpwk_pkg::MASK_IFS) == 8'h00) && ((r_q.pa_sr & ~gpwk_pkg::MASK_PA_SR) == 8'h00))
      else $error("unimplemented select bits became set");
   AST_OUT_DRIVE: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
      ((~r_q.pa_dir & ~pa_share_en & ~pa_analog_en & (pa_oe_n | (pa_out ^ r_q.pa_data))) == '0))
      else $error("output pin not driven from the latch");
   AST_SHARE_DRIVE: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
      r_q.pa_sr[gpwk_pkg::SR_PIN6] && !pa_analog_en[5]
      |-> !pa_oe_n[5] && pa_out[5] == timer_output_inverted)
      else $error("pin 5 not driven by the inverted timer output");
   AST_REMAP_IRQ: assert property (@(posedge ref_clk) disable iff (rst) // RQ15
      r_q.ifs[1:0] == gpwk_pkg::IRQ_ON_PIN7 |-> ext_irq_input == pa_in[7])
      else $error("interrupt input not routed to pin 7");
   AST_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PB_DIR)
      |=> r_q.pb_dir == ($past(bus_req.wdata) & gpwk_pkg::MASK_PB))
      else $error("port B direction write not applied");

   // register bus checks: stray writes, masks and stored values
   AST_NO_STRAY_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      !wr_hit |=> $stable(r_q[$bits(r_q)-1:8]))
      else $error("registers changed without a mapped write");

   AST_UNMAPPED_RD: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      (bus_req.rd && bus_req.addr > gpwk_pkg::OFS_IFS) |=> rd_data == 8'h00)
      else $error("unmapped read returned nonzero");

   AST_PB_MASK: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
      ((r_q.pb_data | r_q.pb_dir | r_q.pb_pu) & ~gpwk_pkg::MASK_PB) == 8'h00
      && (r_q.pb_sr & ~gpwk_pkg::MASK_PB_SR) == 8'h00)
      else $error("unimplemented port B bits became set");

   AST_WU_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ8
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PA_WU)
      |=> r_q.pa_wu == $past(bus_req.wdata))
      else $error("wake enable write not stored");

   AST_PB_PU_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PB_PU)
      |=> r_q.pb_pu == ($past(bus_req.wdata) & gpwk_pkg::MASK_PB))
      else $error("port B pull-high write not stored");

   AST_PA_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PA_DIR)
      |=> r_q.pa_dir == $past(bus_req.wdata))
      else $error("port A direction write not stored");

   AST_PA_DATA_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      (bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PA_DATA)
      |=> r_q.pa_data == $past(bus_req.wdata))
      else $error("port A latch write not stored");

   AST_PB_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
      !(bus_req.wr && bus_req.addr == gpwk_pkg::OFS_PB_DATA) |=> $stable(r_q.pb_data))
      else $error("port B latch changed without a write");

   AST_PB_RD: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
      (bus_req.rd && bus_req.addr == gpwk_pkg::OFS_PB_DATA)
      |=> rd_data == ((($past(r_q.pb_dir) & {2'h0, $past(pb_in)})
                      | (~$past(r_q.pb_dir) & $past(r_q.pb_data))) & gpwk_pkg::MASK_PB))
      else $error("port B read did not return pin on inputs and latch on outputs");

   AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
      !bus_req.rd |=> $stable(rd_data))
      else $error("read data changed without a read");

   // pad checks: drive, pull and analog ownership
   AST_IN_FLOAT: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
      (r_q.pa_dir & ~pa_share_en & ~pa_oe_n) == '0)
      else $error("port A input pin driven");

   AST_PB_OE: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
      ((~r_q.pb_dir[gpwk_pkg::PB_W-1:0] & ~pb_share_en & ~pb_analog_en & pb_oe_n) == '0)
      && ((r_q.pb_dir[gpwk_pkg::PB_W-1:0] & ~pb_share_en & ~pb_oe_n) == '0))
      else $error("port B drive does not follow its direction bits");

   AST_PB_PULL: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
      ((pb_pull & ~r_q.pb_dir[gpwk_pkg::PB_W-1:0]) == '0)
      && ((pb_pull & ~r_q.pb_pu[gpwk_pkg::PB_W-1:0]) == '0))
      else $error("port B pull-high on an output or disabled pin");

   AST_ANALOG_WINS: assert property (@(posedge ref_clk) disable iff (rst) // RQ13
      ((pa_analog_en & (~pa_oe_n | pa_pull)) == '0)
      && ((pb_analog_en & (~pb_oe_n | pb_pull)) == '0))
      else $error("analog pin driven or pulled");

   AST_SHARE_PIN2: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
      r_q.pa_sr[gpwk_pkg::SR_PIN4] && !pa_analog_en[2]
      |-> !pa_oe_n[2] && pa_out[2] == timer_output)
      else $error("pin 2 not driven by the timer output");

   AST_SHARE_PIN1: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
      r_q.pa_sr[gpwk_pkg::SR_PIN2] && !pa_analog_en[1]
      |-> !pa_oe_n[1] && pa_out[1] == timer_output_inverted)
      else $error("pin 1 not driven by the inverted timer output");

   AST_SHARE_PIN0: assert property (@(posedge ref_clk) disable iff (rst) // RQ12
      r_q.pa_sr[gpwk_pkg::SR_PIN0] && !pa_analog_en[0]
      |-> !pa_oe_n[0] && pa_out[0] == timer_output)
      else $error("pin 0 not driven by the timer output");

   AST_PB_SHARE: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
      (pb_share_en & ~pb_analog_en & (pb_oe_n | (pb_out ^ pb_alt_out))) == '0)
      else $error("shared port B pin not driven by its alternate output");

   // remap checks for the non-default timer routes and the default pin 5 interrupt route
   AST_REMAP_TCK: assert property (@(posedge ref_clk) disable iff (rst) // RQ15
      r_q.ifs[gpwk_pkg::IFS_TCK_BIT] |-> timer_clock_input == pa_in[6])
      else $error("timer clock input not routed to pin 6");

   AST_REMAP_CAP: assert property (@(posedge ref_clk) disable iff (rst) // RQ15
      r_q.ifs[gpwk_pkg::IFS_CAP_BIT] |-> timer_capture_input == pa_in[0])
      else $error("capture input not routed to pin 0");

   AST_REMAP_IRQ5: assert property (@(posedge ref_clk) disable iff (rst) // RQ15
      r_q.ifs[1:0] == gpwk_pkg::IRQ_ON_PIN5 |-> ext_irq_input == pa_in[5])
      else $error("interrupt input not routed to pin 5");
endmodule // gpwk_top

/* hw/gpwk_pkg.sv */
package gpwk_pkg;
   // pin counts of the two ports
   localparam int PA_W = 8;
   localparam int PB_W = 6;
   // data memory locations of the port registers
   localparam logic [7:0] OFS_PA_DATA = 8'h00;
   localparam logic [7:0] OFS_PA_DIR = 8'h01;
   localparam logic [7:0] OFS_PA_PU = 8'h02;
   localparam logic [7:0] OFS_PA_WU = 8'h03;
   localparam logic [7:0] OFS_PB_DATA = 8'h04;
   localparam logic [7:0] OFS_PB_DIR = 8'h05;
   localparam logic [7:0] OFS_PB_PU = 8'h06;
   localparam logic [7:0] OFS_PA_SR = 8'h07;
   localparam logic [7:0] OFS_PB_SR = 8'h08;
   localparam logic [7:0] OFS_IFS = 8'h09;
   // reset values
   localparam logic [7:0] RST_PA_DATA = 8'hff;
   localparam logic [7:0] RST_PA_DIR = 8'hff;
   localparam logic [7:0] RST_PB_DATA = 8'h3f;
   localparam logic [7:0] RST_PB_DIR = 8'h3f;
   localparam logic [7:0] RST_CLEAR = 8'h00;
   // implemented bits per register
   localparam logic [7:0] MASK_PB = 8'h3f;
   localparam logic [7:0] MASK_PA_SR = 8'h55;
   localparam logic [7:0] MASK_PB_SR = 8'h3e;
   localparam logic [7:0] MASK_IFS = 8'h33;
   // port A pin-share select bit positions
   localparam int SR_PIN6 = 6;
   localparam int SR_PIN4 = 4;
   localparam int SR_PIN2 = 2;
   localparam int SR_PIN0 = 0;
   // input remap field positions
   localparam int IFS_TCK_BIT = 5;
   localparam int IFS_CAP_BIT = 4;
   localparam int IFS_IRQ_LSB = 0;
   // external interrupt pin codes
   localparam logic [1:0] IRQ_ON_PIN5 = 2'h0;
   localparam logic [1:0] IRQ_ON_PIN2 = 2'h1;
   localparam logic [1:0] IRQ_ON_PIN3 = 2'h2;
   localparam logic [1:0] IRQ_ON_PIN7 = 2'h3;

   // cpu data memory access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gpwk_bus_req_t;

   // register file plus read data
   typedef struct packed {
      logic [7:0] pa_data;
      logic [7:0] pa_dir;
      logic [7:0] pa_pu;
      logic [7:0] pa_wu;
      logic [7:0] pb_data;
      logic [7:0] pb_dir;
      logic [7:0] pb_pu;
      logic [7:0] pa_sr;
      logic [7:0] pb_sr;
      logic [7:0] ifs;
      logic [7:0] rd_data;
   } gpwk_regs_t;

   // wake detector state
   typedef struct packed {
      logic [PA_W-1:0] sync1;
      logic [PA_W-1:0] sync2;
      logic [PA_W-1:0] prev;
      logic wake;
   } gpwk_wake_t;
endpackage

/* hw/gpwk_pad.sv */
`timescale 1ns/1ps
module gpwk_pad #(
   parameter int W = 8
) (
   input wire logic [W-1:0] data,
   input wire logic [W-1:0] dir,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] share_en,
   input wire logic [W-1:0] share_val,
   input wire logic [W-1:0] analog_en,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe_n,
   output logic [W-1:0] pin_pull
);
   // shared timer output overrides the latch and the direction bit
   always_comb begin
      pin_out = (share_en & share_val) | (~share_en & data); // RQ16
      // analog use wins: no digital drive at all
      pin_oe_n = analog_en | (dir & ~share_en); // RQ9 RQ13
      // weak pull only on a plain digital input
      pin_pull = pu & dir & ~share_en & ~analog_en; // RQ3
   end
endmodule // gpwk_pad

/* hw/gpwk_wake.sv */
`timescale 1ns/1ps
module gpwk_wake (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [gpwk_pkg::PA_W-1:0] pin_in,
   input wire logic [gpwk_pkg::PA_W-1:0] wake_en,
   input wire logic sleep_mode,
   output logic wake_req
);
   gpwk_pkg::gpwk_wake_t st_q;
   gpwk_pkg::gpwk_wake_t st_d;
   logic [gpwk_pkg::PA_W-1:0] fall;

   // two flops, then a history flop; only sync2 and prev feed the compare
   always_comb begin
      st_d = st_q;
      st_d.sync1 = pin_in;
      st_d.sync2 = st_q.sync1; // RQ17
      st_d.prev = st_q.sync2;
      fall = st_q.prev & ~st_q.sync2; // RQ17
      st_d.wake = sleep_mode & |(fall & wake_en); // RQ7
   end

   // pins idle high, so history resets high to avoid a false edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= '{sync1: '1, sync2: '1, prev: '1, wake: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign wake_req = st_q.wake;

   AST_WAKE_FALL: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
      (sleep_mode && |(st_q.prev & ~st_q.sync2 & wake_en)) |=> wake_req)
      else $error("enabled falling edge in sleep gave no wake request");
   AST_WAKE_ONCE: assert property (@(posedge ref_clk) disable iff (rst) // RQ17
      (wake_req && $past(pin_in) == pin_in && $past(pin_in, 2) == pin_in
       && $past(pin_in, 3) == pin_in) |=> !wake_req)
      else $error("one falling edge gave more than one wake request");
   AST_WAKE_AWAKE: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
      !sleep_mode |=> !wake_req)
      else $error("wake request raised while not sleeping");
endmodule // gpwk_wake

/* testbench/gpwk_pins_model.sv */
`timescale 1ns/1ps
// external switches, pulls and loads on both ports
module gpwk_pins_model (
   input wire logic ref_clk,
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe_n,
   input wire logic [7:0] pa_pull,
   input wire logic [5:0] pb_out,
   input wire logic [5:0] pb_oe_n,
   input wire logic [5:0] pb_pull,
   input wire logic [7:0] ext_en_a,
   input wire logic [7:0] ext_val_a,
   input wire logic [5:0] ext_en_b,
   input wire logic [5:0] ext_val_b,
   output logic [7:0] pa_in,
   output logic [5:0] pb_in
);
   logic flt_q = 1'b0;
   // a floating pin wanders so a stale level never passes for a real one
   always @(posedge ref_clk) flt_q <= ~flt_q;
   // device drive wins, then a switch, then the weak pull
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pa_in[i] = !pa_oe_n[i] ? pa_out[i] : ext_en_a[i] ? ext_val_a[i] :
                    pa_pull[i] ? 1'b1 : flt_q ^ i[0];
      end
      for (int i = 0; i < 6; i++) begin
         pb_in[i] = !pb_oe_n[i] ? pb_out[i] : ext_en_b[i] ? ext_val_b[i] :
                    pb_pull[i] ? 1'b1 : flt_q ^ i[0];
      end
   end
endmodule // gpwk_pins_model

/* testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin err_total++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, act, exp); end end
module tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   gpwk_pkg::gpwk_bus_req_t bus_req = '0;
   logic [7:0] rd_data, pa_in, pa_out, pa_oe_n, pa_pull;
   logic [5:0] pb_in, pb_out, pb_oe_n, pb_pull;
   logic [7:0] pa_analog_en = 8'h00;
   logic [5:0] pb_analog_en = 6'h00;
   logic [5:0] pb_alt_out = 6'h00;
   logic timer_output = 1'b0;
   logic timer_output_inverted = 1'b0;
   logic sleep_mode = 1'b0;
   logic timer_clock_input, timer_capture_input, ext_irq_input, wake_req;
   logic [7:0] ext_en_a = 8'hff;
   logic [7:0] ext_val_a = 8'ha5;
   logic [5:0] ext_en_b = 6'h3f;
   logic [5:0] ext_val_b = 6'h2a;
   logic [7:0] exp_q[$];
   logic [7:0] exp_v;
   logic rd_seen = 1'b0;
   int err_total = 0;
   int checks_done = 0;
   int wakes = 0;

   gpwk_top i_gpwk_top (.ref_clk, .rst, .bus_req, .rd_data, .pa_in, .pa_out, .pa_oe_n,
      .pa_pull, .pa_analog_en, .pb_in, .pb_out, .pb_oe_n, .pb_pull, .pb_analog_en, .pb_alt_out,
      .timer_output, .timer_output_inverted, .timer_clock_input, .timer_capture_input,
      .ext_irq_input, .sleep_mode, .wake_req);
   gpwk_pins_model i_gpwk_pins_model (.ref_clk, .pa_out, .pa_oe_n, .pa_pull, .pb_out,
      .pb_oe_n, .pb_pull, .ext_en_a, .ext_val_a, .ext_en_b, .ext_val_b, .pa_in, .pb_in);

   initial forever #20 ref_clk = ~ref_clk;

   task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus_req = '{rd: r, wr: !r, addr: a, wdata: d};
      @(negedge ref_clk);
      bus_req = '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b0, a, d);
   endtask
   // the expectation is queued before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      access(1'b1, a, 8'h00);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // read answer is settled by the falling edge after its sampling edge
   always @(posedge ref_clk) rd_seen <= bus_req.rd;
   always @(negedge ref_clk) begin
      if (rd_seen) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         `CHK(rd_data, exp_v)
      end
   end
   // counted away from the edge that launches it, so no race with the flop
   always @(negedge ref_clk) if (wake_req) wakes++;
   // a hang costs a mismatch; the tests need well under 3000 cycles
   initial begin
      #120000;
      err_total++;
      complete_run();
   end

   initial begin
      logic [7:0] r, d, p, e, t;
      logic [7:0] ofs[7];
      logic [7:0] msk[7];
      int pins[4];
      ofs = '{gpwk_pkg::OFS_PA_PU, gpwk_pkg::OFS_PA_WU, gpwk_pkg::OFS_PB_PU,
              gpwk_pkg::OFS_PB_DIR, gpwk_pkg::OFS_PA_SR, gpwk_pkg::OFS_PB_SR, gpwk_pkg::OFS_IFS};
      msk = '{8'hff, 8'hff, gpwk_pkg::MASK_PB, gpwk_pkg::MASK_PB, gpwk_pkg::MASK_PA_SR,
              gpwk_pkg::MASK_PB_SR, gpwk_pkg::MASK_IFS};
      pins = '{5, 2, 3, 7};
      void'($urandom(79));
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      for (int i = 0; i < 7; i++) rd(ofs[i], (i == 3) ? 8'h3f : 8'h00);
      rd(gpwk_pkg::OFS_PA_DIR, 8'hff);
      rd(8'h0a, 8'h00);
      `CHK({pb_oe_n, pa_oe_n, pb_pull, pa_pull}, {14'h3fff, 14'h0000})
      wr(gpwk_pkg::OFS_PA_DIR, 8'h00);
      wr(gpwk_pkg::OFS_PB_DIR, 8'h00);
      rd(gpwk_pkg::OFS_PA_DATA, 8'hff);
      rd(gpwk_pkg::OFS_PB_DATA, 8'h3f);
      `CHK({pb_out, pa_out}, 14'h3fff)
      $display("test reset done");
      // writable bits only, then park everything at zero
      for (int i = 0; i < 7; i++) begin
         d = 8'($urandom);
         wr(ofs[i], d);
         rd(ofs[i], d & msk[i]);
      end
      for (int i = 0; i < 7; i++) wr(ofs[i], 8'h00);
      $display("test register access done");
      repeat (4) begin
         {r, d, p, e} = $urandom;
         {ext_en_b, ext_en_a} = {r[5:0], r} & ~{p[5:0], p};
         {ext_val_b, ext_val_a} = {e[5:0], e};
         for (int k = 0; k < 2; k++) begin
            wr(k ? gpwk_pkg::OFS_PB_DATA : gpwk_pkg::OFS_PA_DATA, d);
            wr(k ? gpwk_pkg::OFS_PB_PU : gpwk_pkg::OFS_PA_PU, p);
            wr(k ? gpwk_pkg::OFS_PB_DIR : gpwk_pkg::OFS_PA_DIR, r);
         end
         `CHK({pb_oe_n, pa_oe_n}, {r[5:0], r})
         `CHK({pb_out, pa_out} & ~{r[5:0], r}, {d[5:0], d} & ~{r[5:0], r})
         `CHK({pb_pull, pa_pull}, {p[5:0], p} & {r[5:0], r})
         rd(gpwk_pkg::OFS_PA_DATA, (d & ~r) | (r & (p | e)));
         ext_val_a = ~e;
         rd(gpwk_pkg::OFS_PA_DATA, (d & ~r) | (r & (p | ~e)));
         rd(gpwk_pkg::OFS_PB_DATA, ((d & ~r) | (r & (p | e))) & 8'h3f);
         wr(gpwk_pkg::OFS_PA_DIR, 8'h00);
         rd(gpwk_pkg::OFS_PA_DATA, d);
      end
      $display("test port io done");
      // shared port A pins follow the timer and port B pins pb_alt_out, whatever the latch and direction say
      wr(gpwk_pkg::OFS_PA_DATA, 8'h00);
      wr(gpwk_pkg::OFS_PA_DIR, 8'hff);
      wr(gpwk_pkg::OFS_PA_PU, 8'hff);
      wr(gpwk_pkg::OFS_PA_SR, 8'h55);
      wr(gpwk_pkg::OFS_PB_SR, 8'h3e);
      ext_en_a = 8'h00;
      for (int j = 0; j < 4; j++) begin
         t = 8'($urandom);
         {timer_output_inverted, timer_output} = j[1:0];
         pb_alt_out = t[5:0];
         @(negedge ref_clk);
         `CHK({pa_out[5], pa_out[2:0]}, {j[1], j[0], j[1], j[0]})
         `CHK({pa_oe_n[5], pa_oe_n[2:0], pb_oe_n[5:1]}, 9'h000)
         `CHK(pb_out[5:1], t[5:1])
      end
      pa_analog_en = 8'h01;
      pb_analog_en = 6'h01;
      @(negedge ref_clk);
      `CHK({pa_oe_n[0], pa_pull[0], pa_pull[3]}, 3'b101)
      `CHK({pb_oe_n[0], pb_pull[0]}, 2'b10)
      wr(gpwk_pkg::OFS_PA_SR, 8'h00);
      wr(gpwk_pkg::OFS_PA_PU, 8'h00);
      $display("test pin share done");
      ext_en_a = 8'hff;
      e = 8'($urandom);
      ext_val_a = e;
      pa_analog_en = 8'h40;
      for (int j = 0; j < 4; j++) begin
         wr(gpwk_pkg::OFS_IFS, {2'b00, j[1:0], 2'b00, j[1:0]});
         `CHK(ext_irq_input, e[pins[j]])
         `CHK(timer_clock_input, j[1] ? e[6] : e[7])
         `CHK(timer_capture_input, j[0] ? e[0] : e[6])
      end
      pa_analog_en = 8'h00;
      pb_analog_en = 6'h00;
      $display("test remap done");
      wr(gpwk_pkg::OFS_PA_WU, 8'h08);
      // enabled pin asleep, disabled pin asleep, enabled pin awake
      for (int j = 0; j < 3; j++) begin
         sleep_mode = (j != 2);
         ext_val_a = 8'hff;
         repeat (5) @(negedge ref_clk);
         wakes = 0;
         ext_val_a = (j == 1) ? 8'hfb : 8'hf7;
         repeat (10) @(negedge ref_clk);
         `CHK(wakes, (j == 0) ? 1 : 0)
      end
      $display("test wake done");
      complete_run();
   end
endmodule // tb
